//--- common/sspm_pkg.sv
// Shared constants and types of the synchronous serial master/slave port
package sspm_pkg;
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_STATUS = 8'h28;
   localparam logic [7:0] IDX_DATA = 8'h29;
   localparam logic [7:0] IDX_CONTROL = 8'h2A;
   localparam logic [7:0] ADDR_STATUS = 8'(4 * int'(IDX_STATUS));
   localparam logic [7:0] ADDR_DATA = 8'(4 * int'(IDX_DATA));
   localparam logic [7:0] ADDR_CONTROL = 8'(4 * int'(IDX_CONTROL));

   // Status field positions
   localparam int ST_DONE = 7;
   localparam int ST_WRITE_COLLISION_FLAG = 6;
   localparam int ST_SLAVE_OVERFLOW_FLAG = 5;
   localparam int ST_MODE_FAULT_FLAG = 4;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // Divide ratios for rate codes 00..11
   localparam logic [6:0] RATIO [4] = '{7'h04, 7'h08, 7'h10, 7'h40};
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [3:0] LAST_EDGE = 4'hF;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic mfd_off;
      logic enable;
      logic lsb_first;
      logic master;
      logic clock_polarity_sel;
      logic clock_phase_sel;
      logic [1:0] rate;
   } sspm_ctrl_t;

   // Synchronised pin levels
   typedef struct packed {
      logic sclk;
      logic mosi;
      logic miso;
      logic ss_n;
   } sspm_pin_t;

   typedef enum logic [0:0] {
      SSPM_IDLE = 1'b0,
      SSPM_XFER = 1'b1
   } sspm_state_t;
endpackage : sspm_pkg

//--- rtl/sspm_port.sv
// Synchronous serial master/slave port with an AXI4-Lite register slave
// Summary of operation
// - Full-duplex serial link over clock, two data lines and a select.
// - Master drives clock pulses only during a transfer, idle otherwise.
// - Each transfer shifts exactly eight bits.
// - Bit order 0 sends MSB first, 1 sends LSB first.
// - Master rate codes divide system clock by 4, 8, 16, 64.
// - Rate field applies only in master role.
// - Polarity 0 idles clock low, 1 idles clock high.
// - Role bit 0 makes a slave, 1 makes a master.
// - Clearing enable mid-transfer takes effect after the transfer.
// - Master data write with port enabled starts a transfer.
// - Fault detect bit 0 enables, 1 disables; master only.
// - A mode fault with detection enabled raises the interrupt.
// - Master with fault detection enabled seeing select low drops its drivers at once.
// - Data write during a transfer flags a write collision.
// - Slave finishing a byte while done is set flags overflow.
// - Phase is control bit 2, polarity control bit 3.
// - Done sets at completion; clears by status read then data access.
// - Slave takes the master clock and ignores the rate field.
// - Slave with select high ignores clock and takes no data.
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
module sspm_port (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sclk_i,
   output logic sclk_o,
   output logic sclk_oe,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe,
   input wire logic ss_n_i,
   output logic irq
);
   sspm_pkg::sspm_pin_t pin_m;
   sspm_pkg::sspm_pin_t pin_s;
   sspm_pkg::sspm_ctrl_t ctrl;
   sspm_pkg::sspm_ctrl_t next_ctrl;
   sspm_pkg::sspm_state_t state;
   sspm_pkg::sspm_state_t next_state;
   logic sclk_d;
   logic [7:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane;
   logic done, write_collision_flag, slave_overflow_flag, mode_fault_flag, arm_d, arm_m;
   logic m_samp;
   logic m_end;
   logic [5:0] div_cnt;
   logic [3:0] edge_cnt;
   logic [2:0] bit_cnt;
   logic [7:0] shreg;
   logic [7:0] rx_data;

   // Pins cross into the clock domain through two flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_m <= '1;
         pin_s <= '1;
         sclk_d <= 1'b1;
      end else begin
         pin_m <= '{sclk: sclk_i, mosi: mosi_i, miso: miso_i, ss_n: ss_n_i};
         pin_s <= pin_m;
         sclk_d <= pin_s.sclk;
      end
   end

   // Write path: address and data held independently, either order
   wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire rd_take = s_axi_arvalid && s_axi_arready;
   wire wr_ctrl = do_write && w_lane && aw_addr == sspm_pkg::ADDR_CONTROL;
   wire wr_data = do_write && w_lane && aw_addr == sspm_pkg::ADDR_DATA;
   wire wr_hit = aw_addr == sspm_pkg::ADDR_CONTROL ||
      aw_addr == sspm_pkg::ADDR_DATA || aw_addr == sspm_pkg::ADDR_STATUS;
   wire rd_stat = rd_take && s_axi_araddr == sspm_pkg::ADDR_STATUS;
   wire rd_data = rd_take && s_axi_araddr == sspm_pkg::ADDR_DATA;
   wire rd_ctrl = rd_take && s_axi_araddr == sspm_pkg::ADDR_CONTROL;
   wire rd_hit = rd_stat || rd_data || rd_ctrl;
   wire [7:0] status_byte = {done, write_collision_flag, slave_overflow_flag, mode_fault_flag, 4'h0};
   wire [7:0] rd_byte = rd_stat ? status_byte :
      rd_data ? rx_data : rd_ctrl ? ctrl : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sspm_pkg::RESP_OKAY;
         aw_addr <= 8'h00;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? sspm_pkg::RESP_OKAY :
               sspm_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read path: one cycle from address to data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= sspm_pkg::RESP_OKAY;
      end else if (rd_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h0, rd_byte};
         s_axi_rresp <= rd_hit ? sspm_pkg::RESP_OKAY : sspm_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Shift engine decode; slave edges come from the synchronised clock
   wire busy = state == sspm_pkg::SSPM_XFER;
   wire port_on = ctrl.enable || busy;
   wire master_run = busy && ctrl.master;
   wire [5:0] half_m1 = sspm_pkg::RATIO[ctrl.rate][6:1] - 6'h01;
   wire tick = master_run && div_cnt == half_m1;
   wire slave_go = !ctrl.master && port_on && !pin_s.ss_n;
   wire s_edge = slave_go && (pin_s.sclk ^ sclk_d);
   wire lead = tick ? sclk_o == ctrl.clock_polarity_sel :
      s_edge && pin_s.sclk != ctrl.clock_polarity_sel;
   wire trail = tick ? sclk_o != ctrl.clock_polarity_sel :
      s_edge && pin_s.sclk == ctrl.clock_polarity_sel;
   wire samp_now = ctrl.clock_phase_sel ? trail : lead;
   // Master samples one clock late: the input sync eats two cycles
   wire sample_ev = ctrl.master ? m_samp : samp_now;
   wire shift_ev = ctrl.clock_phase_sel ? lead : trail;
   wire in_bit = ctrl.master ? pin_s.miso : pin_s.mosi;
   wire head = ctrl.lsb_first ? shreg[0] : shreg[7];
   wire [7:0] shifted = ctrl.lsb_first ? {in_bit, shreg[7:1]} :
      {shreg[6:0], in_bit};
   wire last_sample = sample_ev && bit_cnt == sspm_pkg::LAST_BIT;
   wire xfer_end = ctrl.master ? m_end : last_sample;
   wire start = wr_data && ctrl.master && ctrl.enable && !busy;
   wire load = wr_data && !busy;
   wire write_collision_flag_ev = wr_data && busy;
   wire slave_overflow_flag_ev = xfer_end && !ctrl.master && done;
   wire mf_ev = ctrl.master && ctrl.enable && !ctrl.mfd_off &&
      !pin_s.ss_n;
   wire clr_d = (rd_data || wr_data) && arm_d;
   wire clr_m = wr_ctrl && arm_m;
   wire drv_m = ctrl.master && port_on && !mf_ev;
   wire w_head = ctrl.lsb_first ? w_byte[0] : w_byte[7];
   // A fresh load puts its first bit out before the first clock edge
   wire next_out = load ? w_head : (!busy || shift_ev) ? head : mosi_o;

   // Transfer state; a slave aborts when its select rises
   always_comb begin
      next_state = state;
      case (state)
         sspm_pkg::SSPM_IDLE: begin
            if (start || s_edge) begin
               next_state = sspm_pkg::SSPM_XFER;
            end
         end
         sspm_pkg::SSPM_XFER: begin
            if (xfer_end || mf_ev || (!ctrl.master && pin_s.ss_n)) begin
               next_state = sspm_pkg::SSPM_IDLE;
            end
         end
         default: next_state = sspm_pkg::SSPM_IDLE;
      endcase
   end

   // Control update; a mode fault drops role and enable over any write
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl = w_byte;
      end
      if (mf_ev) begin
         next_ctrl.master = 1'b0;
         next_ctrl.enable = 1'b0;
      end
   end

   // Rate divider and edge counters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= sspm_pkg::SSPM_IDLE;
         ctrl <= sspm_pkg::CTRL_RESET;
         div_cnt <= 6'h00;
         edge_cnt <= 4'h0;
         bit_cnt <= 3'h0;
         m_samp <= 1'b0;
         m_end <= 1'b0;
      end else begin
         state <= next_state;
         ctrl <= next_ctrl;
         m_samp <= tick && samp_now;
         m_end <= tick && edge_cnt == sspm_pkg::LAST_EDGE;
         div_cnt <= (!master_run || tick) ? 6'h00 : div_cnt + 6'h01;
         edge_cnt <= start ? 4'h0 : tick ? edge_cnt + 4'h1 : edge_cnt;
         if (sample_ev) begin
            bit_cnt <= bit_cnt + 3'h1;
         end else if (!busy) begin
            bit_cnt <= 3'h0;
         end
      end
   end

   // Shift register and received byte; overflow keeps the old byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shreg <= sspm_pkg::DATA_RESET;
         rx_data <= sspm_pkg::DATA_RESET;
      end else begin
         if (load) begin
            shreg <= w_byte;
         end else if (sample_ev) begin
            shreg <= shifted;
         end
         if (xfer_end && !slave_overflow_flag_ev) begin
            rx_data <= sample_ev ? shifted : shreg;
         end
      end
   end

   // Sticky flags; a new event wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done <= 1'b0;
         write_collision_flag <= 1'b0;
         slave_overflow_flag <= 1'b0;
         mode_fault_flag <= 1'b0;
         arm_d <= 1'b0;
         arm_m <= 1'b0;
         irq <= 1'b0;
      end else begin
         done <= xfer_end || (done && !clr_d);
         write_collision_flag <= write_collision_flag_ev || (write_collision_flag && !clr_d);
         slave_overflow_flag <= slave_overflow_flag_ev || (slave_overflow_flag && !clr_d && !ctrl.master);
         mode_fault_flag <= mf_ev || (mode_fault_flag && !clr_m);
         arm_d <= rd_stat || (arm_d && !clr_d);
         arm_m <= rd_stat || (arm_m && !clr_m);
         irq <= mode_fault_flag && !ctrl.mfd_off;
      end
   end

   // Pin drivers; clock rests at the polarity level outside transfers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_o <= 1'b0;
         sclk_oe <= 1'b0;
         mosi_o <= 1'b0;
         mosi_oe <= 1'b0;
         miso_o <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         sclk_o <= !master_run ? ctrl.clock_polarity_sel : tick ? !sclk_o : sclk_o;
         sclk_oe <= drv_m;
         mosi_oe <= drv_m;
         miso_oe <= !ctrl.master && port_on;
         mosi_o <= next_out;
         miso_o <= next_out;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_start;
      ctrl.master && ctrl.enable && !busy && wr_data;
   endsequence
   sequence s_first_half;
      !tick ##1 tick;
   endsequence

   property p_idle_clk;
      !master_run |=> sclk_o == $past(ctrl.clock_polarity_sel);
   endproperty
   a_idle_clk: assert property (p_idle_clk)
      else $error("clock not at idle level");
   property p_eight;
      xfer_end |-> bit_cnt == 3'h0 || last_sample;
   endproperty
   a_eight: assert property (p_eight)
      else $error("transfer did not take eight samples");
   property p_rate4;
      tick && ctrl.rate == 2'h0 && edge_cnt != 4'hF |-> ##1 s_first_half;
   endproperty
   a_rate4: assert property (p_rate4)
      else $error("divide by four rate wrong");
   property p_start;
      s_start |=> busy ##1 !sclk_oe || busy;
   endproperty
   a_start: assert property (p_start)
      else $error("data write did not start transfer");
   property p_write_collision_flag;
      wr_data && busy |=> write_collision_flag && shreg != $past(w_byte) || !busy;
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag)
      else $error("write collision not flagged");
   property p_slave_overflow_flag;
      xfer_end && !ctrl.master && done |=> slave_overflow_flag && rx_data == $past(rx_data);
   endproperty
   a_slave_overflow_flag: assert property (p_slave_overflow_flag)
      else $error("overflow not flagged");
   property p_done;
      xfer_end |=> done ##1 done || $past(clr_d);
   endproperty
   a_done: assert property (p_done)
      else $error("done flag lost");
   property p_mode_fault_flag;
      mf_ev |=> !ctrl.master && !ctrl.enable && mode_fault_flag ##1 !sclk_oe && !mosi_oe;
   endproperty
   a_mode_fault_flag: assert property (p_mode_fault_flag)
      else $error("mode fault did not drop drivers");
   property p_irq;
      mode_fault_flag && !ctrl.mfd_off |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("mode fault interrupt missing");
   property p_hold;
      busy && ctrl.master && !ctrl.enable && !mf_ev && !xfer_end |=> busy;
   endproperty
   a_hold: assert property (p_hold)
      else $error("disable cut a transfer short");
   property p_ss;
      !ctrl.master && pin_s.ss_n |-> !sample_ev;
   endproperty
   a_ss: assert property (p_ss)
      else $error("deselected slave took data");
endmodule : sspm_port

//--- testbench/sspm_peer_model.sv
// Peer serial slave facing the port while the port is master
`timescale 1ns/10ps
module sspm_peer_model (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic clock_polarity_sel,
   input wire logic clock_phase_sel,
   input wire logic load,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte
);
   logic [7:0] sr;
   // Load starts a frame; with phase 1 the line is junk until first shift
   always @(posedge load) begin
      sr = tx_byte;
      miso = clock_phase_sel ? ~tx_byte[7] : tx_byte[7];
   end
   // Leading edge leaves the idle level, trailing edge returns to it
   always @(sclk) begin
      if (sclk !== clock_polarity_sel) begin
         if (clock_phase_sel) begin
            miso = sr[7];
            sr = {sr[6:0], ~sr[0]};
         end else begin
            rx_byte = {rx_byte[6:0], mosi};
         end
      end else if (clock_phase_sel) begin
         rx_byte = {rx_byte[6:0], mosi};
      end else begin
         sr = {sr[6:0], ~sr[0]};
         miso = sr[7];
      end
   end
endmodule : sspm_peer_model

//--- testbench/sspm_port_tb_top.sv
// Self-checking bench for the synchronous serial master/slave port
`timescale 1ns/10ps
module sspm_port_tb_top;
   localparam logic [7:0] ST = sspm_pkg::ADDR_STATUS;
   localparam logic [7:0] DA = sspm_pkg::ADDR_DATA;
   localparam logic [7:0] CT = sspm_pkg::ADDR_CONTROL;
   localparam logic [1:0] OK = sspm_pkg::RESP_OKAY;
   logic aclk, aresetn, awvalid, wvalid, arvalid, awready, wready;
   logic bvalid, arready, rvalid, sclk_i, mosi_i, ss_n_i, sclk_o;
   logic sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, m_miso;
   logic m_load, clock_polarity_sel, clock_phase_sel, s_prev;
   logic [7:0] awaddr, araddr, m_tx, m_rx, mtx, ctl, got;
   logic [7:0] sb [3];
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [33:0] exp_r [$];
   logic [1:0] exp_b [$];
   int num_errors = 0, compares = 0, cyc = 0, edges = 0, base = 0;
   int last = 0, half = 2;
   // Released lines: clock keeps its idle level, data pulled high
   wire sclk_w = sclk_oe ? sclk_o : clock_polarity_sel;
   wire mosi_w = mosi_oe ? mosi_o : 1'b1;

   sspm_port i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .sclk_i(sclk_i), .sclk_o(sclk_o),
      .sclk_oe(sclk_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
      .mosi_oe(mosi_oe), .miso_i(m_miso), .miso_o(miso_o),
      .miso_oe(miso_oe), .ss_n_i(ss_n_i), .irq(irq));

   sspm_peer_model i_peer (.sclk(sclk_w), .mosi(mosi_w), .clock_polarity_sel(clock_polarity_sel),
      .clock_phase_sel(clock_phase_sel), .load(m_load), .tx_byte(m_tx), .miso(m_miso),
      .rx_byte(m_rx));

   function automatic logic [7:0] rev(input logic [7:0] v);
      return {<<{v}};
   endfunction : rev

   task automatic chk(input logic [33:0] e, input logic [33:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up

   // Write cycle; upper data bits random since only the low byte counts
   task automatic wr(input logic [7:0] a, d, input logic [1:0] e = OK);
      exp_b.push_back(e);
      awaddr <= a;
      wdata <= {24'($urandom), d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
   endtask : wr

   task automatic rd(input logic [7:0] a, d, input logic [1:0] e = OK);
      exp_r.push_back({e, 24'h000000, d});
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
   endtask : rd

   // Bench as master of a slave-mode port, mode 0, sixteen cycles a bit
   task automatic slv(input logic [7:0] b, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         mosi_i <= b[i];
         repeat (8) @(posedge aclk);
         sclk_i <= 1'b1;
         q[i] = miso_o;
         repeat (8) @(posedge aclk);
         sclk_i <= 1'b0;
      end
   endtask : slv

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // Answers matched to oldest notes; clock edge spacing; hang limit
   always @(posedge aclk) begin
      cyc++;
      if (rvalid) chk(exp_r.pop_front(), {rresp, rdata});
      if (bvalid) chk(34'(exp_b.pop_front()), 34'(bresp));
      if (sclk_o !== s_prev) begin
         if (edges > base && edges < base + 16) chk(half, cyc - last);
         edges++;
         last = cyc;
      end
      s_prev = sclk_o;
      if (cyc > 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   initial begin
      void'($urandom(32'hE5B0F08B));
      {aresetn, awvalid, wvalid, arvalid, sclk_i, mosi_i, m_load} = '0;
      {awaddr, araddr, wdata, m_tx, clock_polarity_sel, clock_phase_sel} = '0;
      ss_n_i = 1'b1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CT, 8'h00);
      rd(ST, 8'h00);
      chk({irq, sclk_oe, mosi_oe, miso_oe}, 4'h0);
      // Every rate code and every clock mode, master role
      for (int k = 0; k < 8; k++) begin
         clock_polarity_sel <= k[2];
         clock_phase_sel <= k[0] ^ k[2];
         m_tx <= 8'($urandom);
         mtx = 8'($urandom);
         half = int'(sspm_pkg::RATIO[k[1:0]]) / 2;
         ctl = {2'b00, k[1], 1'b1, k[2], k[0] ^ k[2], k[1:0]};
         wr(CT, ctl);
         wr(CT, ctl | 8'h40);
         repeat (4) @(posedge aclk);
         chk(sclk_o, clock_polarity_sel);
         m_load <= 1'b1;
         @(posedge aclk);
         m_load <= 1'b0;
         base = edges;
         wr(DA, mtx);
         if (k == 6) wr(DA, ~mtx);
         if (k == 7) wr(CT, ctl);
         for (int n = 0; n < 3000 && edges - base < 16; n++)
            @(posedge aclk);
         repeat (150) @(posedge aclk);
         chk(16, edges - base);
         rd(ST, (k == 6) ? 8'hC0 : 8'h80);
         rd(DA, k[1] ? rev(m_tx) : m_tx);
         rd(ST, 8'h00);
         chk(k[1] ? rev(mtx) : mtx, m_rx);
         if (k == 7) begin
            rd(CT, ctl);
            chk(sclk_oe, 1'b0);
            wr(DA, mtx);
            repeat (100) @(posedge aclk);
            chk(16, edges - base);
         end
      end
      // Mode fault with detection off, then on
      wr(CT, 8'h90);
      wr(CT, 8'hD0);
      ss_n_i <= 1'b0;
      repeat (8) @(posedge aclk);
      rd(ST, 8'h00);
      chk(irq, 1'b0);
      ss_n_i <= 1'b1;
      wr(CT, 8'h10);
      wr(CT, 8'h50);
      ss_n_i <= 1'b0;
      repeat (8) @(posedge aclk);
      chk({irq, sclk_oe, mosi_oe}, 3'b100);
      rd(CT, 8'h00);
      rd(ST, 8'h10);
      wr(CT, 8'h00);
      ss_n_i <= 1'b1;
      rd(ST, 8'h00);
      chk(irq, 1'b0);
      // Slave role with slowest rate code, which must be ignored
      wr(CT, 8'h43);
      repeat (2) @(posedge aclk);
      chk({miso_oe, mosi_oe, sclk_oe}, 3'b100);
      foreach (sb[i]) sb[i] = 8'($urandom);
      mtx = 8'($urandom);
      wr(DA, mtx);
      ss_n_i <= 1'b0;
      slv(sb[0], got);
      chk(mtx, got);
      slv(sb[1], got);
      repeat (8) @(posedge aclk);
      rd(ST, 8'hA0);
      rd(DA, sb[0]);
      rd(ST, 8'h00);
      ss_n_i <= 1'b1;
      slv(sb[2], got);
      repeat (8) @(posedge aclk);
      rd(ST, 8'h00);
      rd(8'h00, 8'h00, sspm_pkg::RESP_SLVERR);
      wr(8'hFC, 8'h55, sspm_pkg::RESP_SLVERR);
      wrap_up();
   end
endmodule : sspm_port_tb_top
